//--- pkg/ccs_defs.svh
// Constants of the control-channel slave: timing counts, address pattern and reset values.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

`define CCS_CLK_PERIOD_NS 4
`define CCS_BYPASS_WAIT_NS 1000000
`define CCS_BYPASS_WAIT_CYC (`CCS_BYPASS_WAIT_NS / `CCS_CLK_PERIOD_NS)
`define CCS_SLAVE_ADDR_HI 6'h24
`define CCS_RW_READ 1'b1
`define CCS_PTR_RESET 8'h00
`define CCS_BYTE_LAST_BIT 4'h8
`define CCS_SEND_LAST_BIT 4'h7
`define CCS_REG_ADDR_W 8
`define CCS_REG_DATA_W 8

`endif

//--- pkg/ccs_pkg.sv
// Types shared by the control-channel slave, its assertion checks and its testbench.
package ccs_pkg;

   typedef enum logic [5:0] {
      CCS_ST_IDLE = 6'h01,
      CCS_ST_RECV = 6'h02,
      CCS_ST_ACK = 6'h04,
      CCS_ST_SEND = 6'h08,
      CCS_ST_MACK = 6'h10,
      CCS_ST_WAIT = 6'h20
   } ccs_state_t;

   typedef enum logic [1:0] {
      CCS_REM_START = 2'h0,
      CCS_REM_WRITE = 2'h1,
      CCS_REM_READ = 2'h2,
      CCS_REM_STOP = 2'h3
   } ccs_rem_op_t;

   typedef struct packed {
      ccs_rem_op_t op;
      logic is_reg_addr;
      logic [7:0] data;
   } ccs_rem_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
   } ccs_rem_rsp_t;

endpackage

//--- src/ccs_regmem.sv
// Register memory of the control-channel slave with a registered read port.
`timescale 1ns/1ps
module ccs_regmem
   import ccs_pkg::*;
#(
   parameter int AW = 8,
   parameter int DW = 8
)
(
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   // No reset on the array, so it maps onto plain memory cells.
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end
endmodule

//--- src/ccs_slave.sv
// Control-channel port: UART bypass pass-through and local I2C slave with remote forwarding.
// What this block does
// - In bypass, UART traffic passes through untouched, never decoded as commands.
// - In bypass, the local registers cannot be reached over the control channel.
// - Mode select driven high places the control channel in bypass mode.
// - Microcontroller on deserializer side: bypass becomes active 1ms after mode select rises.
// - Microcontroller on serializer side: bypass takes effect without added delay.
// - Bypass carries UART both ways at rates down to 10kbps.
// - A local I2C transaction to an address other than 100100X makes the far end act as I2C master.
// - Device may stretch SCL low; the master waits until it is released.
// - SDA and SCL are inputs and open-drain outputs, only pulled low or released.
// - SDA fall with SCL high is START, SDA rise with SCL high is STOP.
// - SDA stays unchanged while SCL is high; one bit per SCL pulse.
// - Ninth clock carries acknowledge: device acks writes, master acks reads.
// - Ack by default when unlocked; withhold when the unlocked-ack enable is low.
// - Respond to address byte 100100X0 for write and 100100X1 for read.
// - Bit after the seven address bits is direction: low write, high read.
// - First written byte loads the pointer; a STOP right after changes nothing else.
// - Write data goes to the pointed register, pointer incrementing after each byte.
// - Reads start at the stored pointer and increment after each returned byte.
// - After a master not-acknowledge the device stops driving data.
// - Command-byte-only select makes the first forwarded byte data, not register address.
// - Default bus address bit X follows the cable type select level.
// - Base mode runs half-duplex, bypass mode runs full-duplex.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_slave
   import ccs_pkg::*;
#(
   parameter int BYPASS_WAIT_CYC = `CCS_BYPASS_WAIT_CYC
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic mode_select_input,
   input wire logic cable_type_select,
   input wire logic mcu_on_serializer_side,
   input wire logic local_ack_when_unlocked,
   input wire logic command_byte_only_select,
   input wire logic link_locked,
   input wire logic mcu_uart_in,
   output logic fwd_uart_out,
   input wire logic rev_uart_in,
   output logic mcu_uart_out,
   output logic bypass_active,
   output logic full_duplex,
   output logic rem_req_valid,
   output ccs_rem_req_t rem_req,
   input wire logic rem_done,
   input wire ccs_rem_rsp_t rem_rsp
);
   function automatic logic [7:0] ccs_inc8(input logic [7:0] v);
      ccs_inc8 = v + 8'h01;
   endfunction

   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic mode_s1, mode_s2, cab_s1, cab_s2;
   logic urx_s1, urx_s2, rev_s1, rev_s2;
   logic addr_x_reg;
   logic [1:0] addr_x_cnt_reg;
   logic [17:0] wait_cnt_reg;
   ccs_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg, ptr_reg;
   logic addr_phase_reg, first_reg, dir_reg, fwd_reg, fetch_reg, nack_reg;
   logic mem_we_reg;
   logic [7:0] mem_waddr_reg, mem_wdata_reg, mem_rdata;
   logic scl_rise, scl_fall, start_det, stop_det, ack_ok, go_send;
   logic [6:0] own_addr;

   // Pins and the reverse link are asynchronous; each passes two flops first.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         {scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3} <= 6'h3f;
         {mode_s1, mode_s2, cab_s1, cab_s2} <= 4'h0;
         {urx_s1, urx_s2, rev_s1, rev_s2} <= 4'hf;
      end
      else
      begin
         {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
         {mode_s1, mode_s2} <= {mode_select_input, mode_s1};
         {cab_s1, cab_s2} <= {cable_type_select, cab_s1};
         {urx_s1, urx_s2} <= {mcu_uart_in, urx_s1};
         {rev_s1, rev_s2} <= {rev_uart_in, rev_s1};
      end
   end

   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   assign ack_ok = link_locked | local_ack_when_unlocked;
   assign own_addr = {`CCS_SLAVE_ADDR_HI, addr_x_reg};
   assign go_send = (state_reg == CCS_ST_ACK) ? dir_reg : ~nack_reg;

   // The strap is copied until its synchroniser holds a real sample, then frozen.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         addr_x_reg <= 1'b0;
         addr_x_cnt_reg <= 2'h0;
      end
      else if (addr_x_cnt_reg != 2'h3)
      begin
         addr_x_reg <= cab_s2;
         addr_x_cnt_reg <= addr_x_cnt_reg + 2'h1;
      end
   end

   // Bypass entry; the wait is dropped at once when mode select falls.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wait_cnt_reg <= 18'h00000;
         bypass_active <= 1'b0;
         full_duplex <= 1'b0;
      end
      else if (!mode_s2)
      begin
         wait_cnt_reg <= 18'h00000;
         bypass_active <= 1'b0;
         full_duplex <= 1'b0;
      end
      else if (mcu_on_serializer_side)
      begin
         bypass_active <= 1'b1;
         full_duplex <= 1'b1;
      end
      else if (wait_cnt_reg >= 18'(BYPASS_WAIT_CYC - 1))
      begin
         bypass_active <= 1'b1;
         full_duplex <= 1'b1;
      end
      else
      begin
         wait_cnt_reg <= wait_cnt_reg + 18'h00001;
      end
   end

   // Bit-level copy in both directions, so any UART rate passes; idle level is high.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         fwd_uart_out <= 1'b1;
         mcu_uart_out <= 1'b1;
      end
      else
      begin
         fwd_uart_out <= bypass_active ? urx_s2 : 1'b1;
         mcu_uart_out <= bypass_active ? rev_s2 : 1'b1;
      end
   end

   // Both pins are only ever pulled low; the wire level comes from the pull-ups.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         scl_oe_n <= 1'b1;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         // Released one cycle after SDA is set up, so SDA never moves with SCL rising.
         scl_oe_n <= (state_reg != CCS_ST_WAIT);
      end
   end

   // I2C byte engine: bits sampled on SCL rise, SDA changed only after SCL fall.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= CCS_ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg <= `CCS_PTR_RESET;
         {addr_phase_reg, first_reg, dir_reg, fwd_reg, fetch_reg, nack_reg} <= 6'h00;
         sda_oe_n <= 1'b1;
         mem_we_reg <= 1'b0;
         mem_waddr_reg <= 8'h00;
         mem_wdata_reg <= 8'h00;
         rem_req_valid <= 1'b0;
         rem_req <= '0;
      end
      else
      begin
         mem_we_reg <= 1'b0;
         rem_req_valid <= 1'b0;
         if (mode_s2)
         begin
            state_reg <= CCS_ST_IDLE;
            sda_oe_n <= 1'b1;
            fwd_reg <= 1'b0;
         end
         else if (start_det)
         begin
            state_reg <= CCS_ST_RECV;
            bit_cnt_reg <= 4'h0;
            addr_phase_reg <= 1'b1;
            sda_oe_n <= 1'b1;
         end
         else if (stop_det)
         begin
            // A STOP after the pointer byte leaves only the pointer changed.
            state_reg <= CCS_ST_IDLE;
            sda_oe_n <= 1'b1;
            fwd_reg <= 1'b0;
            if (fwd_reg)
            begin
               rem_req_valid <= 1'b1;
               rem_req <= '{op: CCS_REM_STOP, is_reg_addr: 1'b0, data: 8'h00};
            end
         end
         else
         begin
            unique case (state_reg)
               CCS_ST_IDLE:
               begin
               end
               CCS_ST_RECV:
               begin
                  if (scl_rise)
                  begin
                     shift_reg <= {shift_reg[6:0], sda_s2};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
                  else if (scl_fall && bit_cnt_reg == `CCS_BYTE_LAST_BIT)
                  begin
                     first_reg <= addr_phase_reg;
                     if (addr_phase_reg)
                     begin
                        addr_phase_reg <= 1'b0;
                        dir_reg <= (shift_reg[0] == `CCS_RW_READ);
                        if (shift_reg[7:1] == own_addr)
                        begin
                           fwd_reg <= 1'b0;
                           sda_oe_n <= ~ack_ok;
                           state_reg <= ack_ok ? CCS_ST_ACK : CCS_ST_IDLE;
                        end
                        else
                        begin
                           fwd_reg <= 1'b1;
                           fetch_reg <= 1'b0;
                           rem_req_valid <= 1'b1;
                           rem_req <= '{op: CCS_REM_START, is_reg_addr: 1'b0, data: shift_reg};
                           state_reg <= CCS_ST_WAIT;
                        end
                     end
                     else if (fwd_reg)
                     begin
                        fetch_reg <= 1'b0;
                        rem_req_valid <= 1'b1;
                        rem_req <= '{op: CCS_REM_WRITE, is_reg_addr: first_reg & ~command_byte_only_select,
                                     data: shift_reg};
                        state_reg <= CCS_ST_WAIT;
                     end
                     else
                     begin
                        if (first_reg)
                        begin
                           ptr_reg <= shift_reg;
                        end
                        else
                        begin
                           mem_we_reg <= 1'b1;
                           mem_waddr_reg <= ptr_reg;
                           mem_wdata_reg <= shift_reg;
                           ptr_reg <= ccs_inc8(ptr_reg);
                        end
                        sda_oe_n <= ~ack_ok;
                        state_reg <= ack_ok ? CCS_ST_ACK : CCS_ST_IDLE;
                     end
                  end
               end
               CCS_ST_ACK, CCS_ST_MACK:
               begin
                  if (scl_rise && state_reg == CCS_ST_MACK)
                  begin
                     nack_reg <= sda_s2;
                  end
                  else if (scl_fall)
                  begin
                     sda_oe_n <= 1'b1;
                     bit_cnt_reg <= 4'h0;
                     if (!dir_reg)
                     begin
                        state_reg <= CCS_ST_RECV;
                     end
                     else if (!go_send)
                     begin
                        state_reg <= CCS_ST_IDLE;
                     end
                     else if (fwd_reg)
                     begin
                        fetch_reg <= 1'b1;
                        rem_req_valid <= 1'b1;
                        rem_req <= '{op: CCS_REM_READ, is_reg_addr: 1'b0, data: 8'h00};
                        state_reg <= CCS_ST_WAIT;
                     end
                     else
                     begin
                        shift_reg <= mem_rdata;
                        sda_oe_n <= mem_rdata[7];
                        ptr_reg <= ccs_inc8(ptr_reg);
                        state_reg <= CCS_ST_SEND;
                     end
                  end
               end
               CCS_ST_SEND:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt_reg == `CCS_SEND_LAST_BIT)
                     begin
                        sda_oe_n <= 1'b1;
                        state_reg <= CCS_ST_MACK;
                     end
                     else
                     begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        sda_oe_n <= shift_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               CCS_ST_WAIT:
               begin
                  // SCL is held low here, so SDA may change freely.
                  if (rem_done)
                  begin
                     bit_cnt_reg <= 4'h0;
                     if (fetch_reg)
                     begin
                        shift_reg <= rem_rsp.rdata;
                        sda_oe_n <= rem_rsp.rdata[7];
                        state_reg <= CCS_ST_SEND;
                     end
                     else if (rem_rsp.ack && ack_ok)
                     begin
                        sda_oe_n <= 1'b0;
                        state_reg <= CCS_ST_ACK;
                     end
                     else
                     begin
                        state_reg <= CCS_ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Read data follow the pointer one cycle late; SCL edges are far slower than that.
   ccs_regmem #(
      .AW(`CCS_REG_ADDR_W),
      .DW(`CCS_REG_DATA_W)
   ) u_regmem (
      .clk(core_clk),
      .we(mem_we_reg),
      .waddr(mem_waddr_reg),
      .wdata(mem_wdata_reg),
      .raddr(ptr_reg),
      .rdata(mem_rdata)
   );
endmodule

//--- verification/ccs_slave_asserts.sv
// Port-level checks of the control-channel slave.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_slave_asserts
   import ccs_pkg::*;
#(
   parameter int BYPASS_WAIT_CYC = `CCS_BYPASS_WAIT_CYC
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe_n,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire logic mode_select_input,
   input wire logic cable_type_select,
   input wire logic mcu_on_serializer_side,
   input wire logic local_ack_when_unlocked,
   input wire logic command_byte_only_select,
   input wire logic link_locked,
   input wire logic mcu_uart_in,
   input wire logic fwd_uart_out,
   input wire logic rev_uart_in,
   input wire logic mcu_uart_out,
   input wire logic bypass_active,
   input wire logic full_duplex,
   input wire logic rem_req_valid,
   input wire ccs_rem_req_t rem_req,
   input wire logic rem_done,
   input wire ccs_rem_rsp_t rem_rsp
);
   logic [31:0] ms_cnt;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Counted from the raw pin, so synchroniser lag can only make bypass later, never earlier.
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         ms_cnt <= 32'h0;
      end
      else if (!mode_select_input)
      begin
         ms_cnt <= 32'h0;
      end
      else
      begin
         ms_cnt <= ms_cnt + 32'h1;
      end
   end
   property p_od; !scl_out && !sda_out; endproperty
   a_od: assert property (p_od) else $error("open-drain pin driven high");
   property p_fdx; full_duplex == bypass_active; endproperty
   a_fdx: assert property (p_fdx) else $error("duplex does not follow bypass");
   property p_uart; bypass_active && $past(bypass_active, 3)
      |-> fwd_uart_out == $past(mcu_uart_in, 3) && mcu_uart_out == $past(rev_uart_in, 3); endproperty
   a_uart: assert property (p_uart) else $error("uart copy wrong");
   property p_idle; !bypass_active && !$past(bypass_active) |-> fwd_uart_out && mcu_uart_out; endproperty
   a_idle: assert property (p_idle) else $error("uart passed outside bypass");
   property p_late; $rose(bypass_active) && !mcu_on_serializer_side |-> ms_cnt >= BYPASS_WAIT_CYC; endproperty
   a_late: assert property (p_late) else $error("bypass came too early");
   property p_fast; $rose(mode_select_input) && mcu_on_serializer_side |-> ##[1:6] bypass_active; endproperty
   a_fast: assert property (p_fast) else $error("bypass delayed");
   property p_off; $fell(mode_select_input) |-> ##[1:5] !bypass_active; endproperty
   a_off: assert property (p_off) else $error("bypass stays after mode drop");
   property p_quiet; mode_select_input && $past(mode_select_input, 4) |-> sda_oe_n; endproperty
   a_quiet: assert property (p_quiet) else $error("i2c answer in bypass");
   property p_unlock; !link_locked && !local_ack_when_unlocked |-> sda_oe_n; endproperty
   a_unlock: assert property (p_unlock) else $error("ack while unlocked");
   property p_cause; $fell(scl_oe_n) |-> $past(rem_req_valid); endproperty
   a_cause: assert property (p_cause) else $error("stretch without request");
   property p_rel; rem_done && !scl_oe_n |-> ##[1:2] scl_oe_n; endproperty
   a_rel: assert property (p_rel) else $error("stretch not released");
   property p_pulse; rem_req_valid |=> !rem_req_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("request not a pulse");
   property p_chg; $changed(sda_oe_n) |-> !scl_in && !$past(scl_in); endproperty
   a_chg: assert property (p_chg) else $error("sda moved while scl high");
   c_bypass: cover property ($rose(bypass_active));
   c_stretch: cover property ($fell(scl_oe_n));
   c_ack: cover property ($fell(sda_oe_n));
endmodule

//--- verification/ccs_mcu_model.sv
// Host model: I2C master on open-drain SCL and SDA that waits out clock stretching.
`timescale 1ns/1ps
module ccs_mcu_model
(
   input wire logic core_clk,
   input wire logic scl_w,
   input wire logic sda_w,
   output logic scl_rel,
   output logic sda_rel,
   output logic hang
);
   localparam int QTR = 8;
   initial
   begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      hang = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic bitx(input logic b, output logic r);
      int i;
      sda_rel = b;
      tick(QTR);
      scl_rel = 1'b1;
      for (i = 0; i < 4000 && scl_w !== 1'b1; i++)
         tick(1);
      hang = hang | (i >= 4000);
      tick(QTR);
      r = sda_w;
      tick(QTR);
      scl_rel = 1'b0;
      tick(QTR);
   endtask
   task automatic i2c_start();
      sda_rel = 1'b1;
      tick(QTR);
      scl_rel = 1'b1;
      tick(QTR);
      sda_rel = 1'b0;
      tick(QTR);
      scl_rel = 1'b0;
      tick(QTR);
   endtask
   task automatic i2c_stop();
      sda_rel = 1'b0;
      tick(QTR);
      scl_rel = 1'b1;
      tick(2 * QTR);
      sda_rel = 1'b1;
      tick(2 * QTR);
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int k = 7; k >= 0; k--)
         bitx(d[k], r);
      bitx(1'b1, r);
      ack = (r === 1'b0);
   endtask
   task automatic rd_byte(input logic mack, output logic [7:0] d);
      logic r;
      for (int k = 7; k >= 0; k--)
         bitx(1'b1, d[k]);
      bitx(!mack, r);
   endtask
endmodule

//--- verification/ccs_slave_tb_top.sv
// Self-checking bench of the control-channel slave with host model and far-end responder.
`timescale 1ns/1ps
module ccs_slave_tb_top
   import ccs_pkg::*;
;
   localparam int WAIT_CYC = 50;
   typedef struct packed {logic [7:0] ptr; logic [7:0] d0; logic [7:0] d1;} ccs_row_t;
   logic core_clk, rst, mode_select_input, cable_type_select, mcu_on_serializer_side, link_locked;
   logic local_ack_when_unlocked, command_byte_only_select, mcu_uart_in, rev_uart_in, rem_done;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, fwd_uart_out, mcu_uart_out, bypass_active, full_duplex;
   logic rem_req_valid, m_scl, m_sda, m_hang, ack_s;
   logic [7:0] rd_s;
   wire scl_w, sda_w;
   ccs_rem_req_t rem_req;
   ccs_rem_rsp_t rem_rsp;
   ccs_rem_req_t req_q[$];
   int err_count, compares;
   ccs_row_t rows [3] = '{'{8'h05, 8'haa, 8'h55}, '{8'hfe, 8'h01, 8'h80}, '{8'h40, 8'h00, 8'hff}};
   // Pull-ups hold a released line high; whoever pulls low wins.
   assign scl_w = m_scl & (scl_oe_n | scl_out);
   assign sda_w = m_sda & (sda_oe_n | sda_out);
   ccs_slave #(.BYPASS_WAIT_CYC(WAIT_CYC)) dut (.core_clk, .rst, .scl_in(scl_w), .scl_out, .scl_oe_n,
      .sda_in(sda_w), .sda_out, .sda_oe_n, .mode_select_input, .cable_type_select, .mcu_on_serializer_side,
      .local_ack_when_unlocked, .command_byte_only_select, .link_locked, .mcu_uart_in, .fwd_uart_out,
      .rev_uart_in, .mcu_uart_out, .bypass_active, .full_duplex, .rem_req_valid, .rem_req, .rem_done, .rem_rsp);
   ccs_mcu_model mcu (.core_clk, .scl_w, .sda_w, .scl_rel(m_scl), .sda_rel(m_sda), .hang(m_hang));
   always #2 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic wr_seq(input logic [7:0] a, input logic [23:0] b, input int n, input logic ack_e);
      logic ack;
      mcu.i2c_start();
      mcu.wr_byte(a, ack);
      chk("addr ack", 16'(ack), 16'(ack_e));
      for (int k = 0; k < n; k++)
      begin
         mcu.wr_byte(b[23 - 8 * k -: 8], ack);
         chk("data ack", 16'(ack), 16'(ack_e));
      end
      mcu.i2c_stop();
   endtask
   task automatic rd_seq(input logic [7:0] e0, input logic [7:0] e1);
      logic ack;
      logic [7:0] d;
      mcu.i2c_start();
      mcu.wr_byte(8'h93, ack);
      chk("read addr ack", 16'(ack), 16'h0001);
      mcu.rd_byte(1'b1, d);
      chk("read byte 0", 16'(d), 16'(e0));
      mcu.rd_byte(1'b0, d);
      chk("read byte 1", 16'(d), 16'(e1));
      chk("sda after nack", 16'(sda_oe_n), 16'h0001);
      mcu.i2c_stop();
   endtask
   // The far end answers late on purpose, so that every forwarded byte is stretched.
   initial
   begin
      forever
      begin
         @(posedge core_clk);
         #1;
         if (rem_req_valid === 1'b1)
         begin
            req_q.push_back(rem_req);
            repeat (40) @(posedge core_clk);
            #1 rem_done = 1'b1;
            @(posedge core_clk);
            #1 rem_done = 1'b0;
         end
      end
   end
   always @(posedge m_hang)
   begin
      err_count++;
      test_done();
   end
   initial
   begin
      repeat (100000) @(posedge core_clk);
      err_count++;
      test_done();
   end
   initial
   begin
      core_clk = 1'b0;
      rst = 1'b1;
      {mode_select_input, mcu_on_serializer_side, command_byte_only_select, rem_done} = 4'h0;
      {cable_type_select, local_ack_when_unlocked, link_locked, mcu_uart_in, rev_uart_in} = 5'h1f;
      rem_rsp = '{ack: 1'b1, rdata: 8'h3c};
      repeat (3) @(posedge core_clk);
      #1;
      chk("reset outs", 16'({scl_oe_n, sda_oe_n, fwd_uart_out, mcu_uart_out, bypass_active, full_duplex,
         rem_req_valid}), 16'h0078);
      repeat (3) @(posedge core_clk);
      #1 rst = 1'b0;
      mcu.tick(10);
      foreach (rows[i])
      begin
         wr_seq(8'h92, {rows[i].ptr, rows[i].d0, rows[i].d1}, 3, 1'b1);
         wr_seq(8'h92, {rows[i].ptr, 16'h0000}, 1, 1'b1);
         rd_seq(rows[i].d0, rows[i].d1);
      end
      link_locked = 1'b0;
      wr_seq(8'h92, 24'h050000, 1, 1'b1);
      local_ack_when_unlocked = 1'b0;
      wr_seq(8'h92, 24'h050000, 1, 1'b0);
      {link_locked, local_ack_when_unlocked} = 2'h3;
      for (int c = 0; c < 2; c++)
      begin
         command_byte_only_select = c[0];
         req_q.delete();
         wr_seq(8'h90, 24'h112200, 2, 1'b1);
         mcu.tick(60);
         chk("req count", 16'(req_q.size()), 16'h0004);
         chk("req ops", 16'({req_q[0].op, req_q[1].op, req_q[2].op, req_q[3].op}), 16'h0017);
         chk("reg flag", 16'({req_q[1].is_reg_addr, req_q[2].is_reg_addr}), 16'({~c[0], 1'b0}));
         chk("fwd data", {req_q[1].data, req_q[2].data}, 16'h1122);
      end
      rem_rsp = '{ack: 1'b1, rdata: 8'ha5};
      req_q.delete();
      mcu.i2c_start();
      mcu.wr_byte(8'h91, ack_s);
      chk("fwd rd ack", 16'(ack_s), 16'h0001);
      mcu.rd_byte(1'b0, rd_s);
      chk("fwd rd data", 16'(rd_s), 16'h00a5);
      mcu.i2c_stop();
      rem_rsp = '{ack: 1'b0, rdata: 8'h00};
      wr_seq(8'h90, 24'h330000, 1, 1'b0);
      mcu.tick(60);
      chk("fwd rd count", 16'(req_q.size()), 16'h0005);
      chk("fwd rd ops", 16'({req_q[0].op, req_q[1].op, req_q[2].op, req_q[3].op,
         req_q[4].op}), 16'h00b3);
      rst = 1'b1;
      cable_type_select = 1'b0;
      mcu.tick(2);
      chk("reset again", 16'({scl_oe_n, sda_oe_n, bypass_active, rem_req_valid}), 16'h000c);
      rst = 1'b0;
      mcu.tick(4);
      req_q.delete();
      wr_seq(8'h90, 24'h050000, 1, 1'b1);
      mcu.tick(60);
      chk("strap addr", 16'(req_q.size()), 16'h0000);
      mode_select_input = 1'b1;
      mcu.tick(WAIT_CYC - 10);
      chk("bypass early", 16'(bypass_active), 16'h0000);
      for (int i = 0; i < 40 && bypass_active !== 1'b1; i++)
         mcu.tick(1);
      chk("bypass live", 16'({bypass_active, full_duplex}), 16'h0003);
      if (bypass_active !== 1'b1)
         test_done();
      for (int k = 0; k < 16; k++)
      begin
         mcu_uart_in = k[0] ^ k[2];
         rev_uart_in = k[1];
         mcu.tick(5);
         chk("uart", 16'({fwd_uart_out, mcu_uart_out}), 16'({mcu_uart_in, rev_uart_in}));
         mcu.tick(3);
      end
      {mcu_uart_in, rev_uart_in} = 2'h3;
      wr_seq(8'h92, 24'h050000, 1, 1'b0);
      mode_select_input = 1'b0;
      mcu.tick(8);
      chk("bypass off", 16'(bypass_active), 16'h0000);
      mcu_on_serializer_side = 1'b1;
      mode_select_input = 1'b1;
      mcu.tick(6);
      chk("bypass fast", 16'(bypass_active), 16'h0001);
      mode_select_input = 1'b0;
      mcu.tick(8);
      test_done();
   end
endmodule
bind ccs_slave ccs_slave_asserts #(.BYPASS_WAIT_CYC(BYPASS_WAIT_CYC)) u_chk (.core_clk, .rst, .scl_in, .scl_out,
   .scl_oe_n, .sda_in, .sda_out, .sda_oe_n, .mode_select_input, .cable_type_select, .mcu_on_serializer_side,
   .local_ack_when_unlocked, .command_byte_only_select, .link_locked, .mcu_uart_in, .fwd_uart_out, .rev_uart_in,
   .mcu_uart_out, .bypass_active, .full_duplex, .rem_req_valid, .rem_req, .rem_done, .rem_rsp);
